// ===== rtl/mdma_engine.sv
// multichannel transfer engine: register port, arbiter, channel state,
// one read-then-write item at a time over a peripheral and a memory master
// assumes masters return read data right-justified and answer with ready_in;
// a peripheral drops its request on the edge after it sees its acknowledge
//
// Chosen here: the address map and the strobed register port.
`include "mdma_consts.svh"

module mdma_engine #(
    parameter int NCH   = 7,
    parameter int CNT_W = 17
) (
    input  wire logic           clk_sys_in,
    input  wire logic           reset_in,
    input  wire logic [7:0]     reg_addr_in,
    input  wire logic [31:0]    reg_wdata_in,
    input  wire logic           reg_write_in,
    input  wire logic           reg_read_in,
    output logic      [31:0]    reg_rdata_out,
    input  wire logic [NCH-1:0] periph_req_in,
    output logic      [NCH-1:0] periph_ack_out,
    output logic      [NCH-1:0] irq_out,
    output logic                per_valid_out,
    output logic                per_write_out,
    output logic      [1:0]     per_size_out,
    output logic      [31:0]    per_addr_out,
    output logic      [31:0]    per_wdata_out,
    input  wire logic           per_ready_in,
    input  wire logic [31:0]    per_rdata_in,
    input  wire logic           per_err_in,
    output logic                mem_valid_out,
    output logic                mem_write_out,
    output logic      [1:0]     mem_size_out,
    output logic      [31:0]    mem_addr_out,
    output logic      [31:0]    mem_wdata_out,
    input  wire logic           mem_ready_in,
    input  wire logic [31:0]    mem_rdata_in,
    input  wire logic           mem_err_in
);

    localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;

    typedef struct packed {
        mdma_pkg::mdma_phase_e                phase;
        logic [NCH-1:0][`MDMA_CTL_W-1:0]      ctl;
        logic [NCH-1:0][CNT_W-1:0]            items_left;
        logic [NCH-1:0][CNT_W-1:0]            reload;
        logic [NCH-1:0][`MDMA_FLAG_W-1:0]     flags;
        logic [CH_W-1:0]                      ch;
        logic [31:0]                          dst_addr;
        logic                                 cmd_valid;
        logic                                 cmd_write;
        logic                                 cmd_to_per;
        logic [1:0]                           cmd_size;
        logic [31:0]                          cmd_addr;
        logic [31:0]                          cmd_wdata;
        logic [NCH-1:0]                       ack;
        logic [31:0]                          rdata;
        logic                                 rd_mem;
        logic                                 rd_hi;
    } mdma_regs_s;

    mdma_regs_s state_reg;
    mdma_regs_s state_next;

    // base-address memory hookup
    logic [1:0]      base_wr_lane;
    logic [CH_W-1:0] base_wr_idx;
    logic [CH_W-1:0] base_rd_a_idx;
    logic [63:0]     base_rd_a_data;
    logic [CH_W-1:0] base_rd_b_idx;
    logic [63:0]     base_rd_b_data;

    // per-item working values
    logic            cmd_ready;
    logic            cmd_err;
    logic [31:0]     cmd_rdata;
    logic [NCH-1:0]  eligible;
    logic            best_found;
    logic [CH_W-1:0] best_idx;
    logic [1:0]      best_rank;
    logic [NCH-1:0]  set_full;
    logic [NCH-1:0]  set_half;
    logic [NCH-1:0]  set_fault;
    logic [NCH-1:0][`MDMA_FLAG_W-1:0] clr_flags;

    // mask of the valid low bits for an item size
    function automatic logic [31:0] size_mask(input logic [1:0] size);
        logic [31:0] m;
        m = 32'hFFFF_FFFF;
        if (size == `MDMA_SIZE_8) begin
            m = 32'h0000_00FF;
        end else if (size == `MDMA_SIZE_16) begin
            m = 32'h0000_FFFF;
        end
        return m;
    endfunction : size_mask

    // item address: base, or base plus items done times item bytes
    function automatic logic [31:0] item_addr(input logic [31:0] base,
                                              input logic        step_on,
                                              input logic [1:0]  size,
                                              input logic [31:0] done);
        logic [31:0] offs;
        offs = done;
        if (size == `MDMA_SIZE_16) begin
            offs = {done[30:0], 1'b0};
        end else if (size != `MDMA_SIZE_8) begin
            offs = {done[29:0], 2'b00};
        end
        return step_on ? base + offs : base;
    endfunction : item_addr

    // the answer comes from whichever master holds the command
    assign cmd_ready = state_reg.cmd_to_per ? per_ready_in : mem_ready_in;
    assign cmd_err   = state_reg.cmd_to_per ? per_err_in : mem_err_in;
    assign cmd_rdata = state_reg.cmd_to_per ? per_rdata_in : mem_rdata_in;

    // arbiter: walk down so an equal rank lets the lower index win
    always_comb begin
        best_found = 1'b0;
        best_idx   = '0;
        best_rank  = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            // a channel acknowledged last cycle waits for its request to drop
            eligible[i] = state_reg.ctl[i][`MDMA_CTL_ON]
                        && (state_reg.items_left[i] != '0)
                        && (state_reg.ctl[i][`MDMA_CTL_M2M] || periph_req_in[i])
                        && !state_reg.ack[i];
            if (eligible[i] && (!best_found
                    || state_reg.ctl[i][`MDMA_CTL_RANK +: 2] >= best_rank)) begin
                best_found = 1'b1;
                best_idx   = CH_W'(i);
                best_rank  = state_reg.ctl[i][`MDMA_CTL_RANK +: 2];
            end
        end
    end

    // whole next-state: register port, engine, flags
    always_comb begin
        logic [7:0]       ch_off;
        logic             held;
        logic [CH_W-1:0]  c;
        logic [31:0]      done;
        logic [31:0]      p_addr;
        logic [31:0]      m_addr;
        logic [31:0]      item;
        logic [CNT_W-1:0] left_new;
        logic [CNT_W-1:0] half_pt;
        logic             on_per;
        ch_off       = 8'h00;
        held         = 1'b0;
        c            = state_reg.ch;
        done         = '0;
        p_addr       = '0;
        m_addr       = '0;
        item         = '0;
        left_new     = '0;
        half_pt      = '0;
        on_per       = 1'b0;
        state_next   = state_reg;
        state_next.ack    = '0;
        state_next.rdata  = `MDMA_WORD_RST;
        state_next.rd_mem = 1'b0;
        base_wr_lane  = 2'b00;
        base_wr_idx   = '0;
        base_rd_a_idx = '0;
        base_rd_b_idx = (state_reg.phase == mdma_pkg::PH_IDLE) ? best_idx : state_reg.ch;
        set_full  = '0;
        set_half  = '0;
        set_fault = '0;
        clr_flags = '0;

        // flag clear word: the global clear bit wipes all four
        if (reg_write_in && reg_addr_in == `MDMA_OFF_CLEAR) begin
            for (int i = 0; i < NCH; i++) begin
                clr_flags[i] = reg_wdata_in[i*`MDMA_FLAG_W +: `MDMA_FLAG_W];
                if (clr_flags[i][`MDMA_FLAG_ANY]) begin
                    clr_flags[i] = '1;
                end
            end
        end
        if (reg_read_in && reg_addr_in == `MDMA_OFF_FLAGS) begin
            for (int i = 0; i < NCH; i++) begin
                state_next.rdata[i*`MDMA_FLAG_W +: `MDMA_FLAG_W] = state_reg.flags[i];
            end
        end

        // channel registers; count and bases are refused while a channel is
        // on or has an item in flight, so the engine never races the bus
        for (int i = 0; i < NCH; i++) begin
            ch_off = 8'(i) * `MDMA_CH_STRIDE;
            held   = state_reg.ctl[i][`MDMA_CTL_ON]
                   || (state_reg.phase != mdma_pkg::PH_IDLE && state_reg.ch == CH_W'(i));
            if (reg_write_in) begin
                if (reg_addr_in == `MDMA_OFF_CTL + ch_off) begin
                    state_next.ctl[i] = reg_wdata_in[`MDMA_CTL_W-1:0];
                    if (state_reg.ctl[i][`MDMA_CTL_ON]) begin
                        state_next.ctl[i][`MDMA_CTL_M2M] =
                            state_reg.ctl[i][`MDMA_CTL_M2M];
                    end
                end
                if (reg_addr_in == `MDMA_OFF_CNT + ch_off && !held) begin
                    state_next.reload[i]     = reg_wdata_in[CNT_W-1:0];
                    state_next.items_left[i] = reg_wdata_in[CNT_W-1:0];
                end
                if ((reg_addr_in == `MDMA_OFF_PADDR + ch_off
                        || reg_addr_in == `MDMA_OFF_MADDR + ch_off) && !held) begin
                    state_next.items_left[i] = state_reg.reload[i];
                    base_wr_idx  = CH_W'(i);
                    base_wr_lane = (reg_addr_in == `MDMA_OFF_MADDR + ch_off) ? 2'b10 : 2'b01;
                end
            end
            if (reg_read_in) begin
                if (reg_addr_in == `MDMA_OFF_CTL + ch_off) begin
                    state_next.rdata[`MDMA_CTL_W-1:0] = state_reg.ctl[i];
                end
                if (reg_addr_in == `MDMA_OFF_CNT + ch_off) begin
                    state_next.rdata[CNT_W-1:0] = state_reg.items_left[i];
                end
                if (reg_addr_in == `MDMA_OFF_PADDR + ch_off
                        || reg_addr_in == `MDMA_OFF_MADDR + ch_off) begin
                    base_rd_a_idx     = CH_W'(i);
                    state_next.rd_mem = 1'b1;
                    state_next.rd_hi  = (reg_addr_in == `MDMA_OFF_MADDR + ch_off);
                end
            end
        end

        // transfer engine, one item at a time
        on_per = state_reg.cmd_to_per && !state_reg.ctl[c][`MDMA_CTL_M2M];
        case (state_reg.phase)
            mdma_pkg::PH_IDLE: begin
                // disabling simply stops picking the channel; count stays put
                if (best_found) begin
                    state_next.ch    = best_idx;
                    state_next.phase = mdma_pkg::PH_FETCH;
                end
            end
            mdma_pkg::PH_FETCH: begin
                // bases arrive now; addresses follow from the items done
                done   = 32'(state_reg.reload[c] - state_reg.items_left[c]);
                p_addr = item_addr(base_rd_b_data[31:0],
                                   state_reg.ctl[c][`MDMA_CTL_PSTEP],
                                   state_reg.ctl[c][`MDMA_CTL_PSIZE +: 2], done);
                m_addr = item_addr(base_rd_b_data[63:32],
                                   state_reg.ctl[c][`MDMA_CTL_MSTEP],
                                   state_reg.ctl[c][`MDMA_CTL_MSIZE +: 2], done);
                state_next.cmd_valid  = 1'b1;
                state_next.cmd_write  = 1'b0;
                if (state_reg.ctl[c][`MDMA_CTL_DIR]) begin
                    state_next.cmd_to_per = 1'b0;
                    state_next.cmd_size   = state_reg.ctl[c][`MDMA_CTL_MSIZE +: 2];
                    state_next.cmd_addr   = m_addr;
                    state_next.dst_addr   = p_addr;
                end else begin
                    state_next.cmd_to_per = 1'b1;
                    state_next.cmd_size   = state_reg.ctl[c][`MDMA_CTL_PSIZE +: 2];
                    state_next.cmd_addr   = p_addr;
                    state_next.dst_addr   = m_addr;
                end
                state_next.phase = mdma_pkg::PH_READ;
            end
            mdma_pkg::PH_READ: begin
                if (cmd_ready) begin
                    state_next.cmd_valid = 1'b0;
                    state_next.ack[c]    = on_per;
                    if (cmd_err) begin
                        // a failed item is not counted and the channel stops
                        set_fault[c] = 1'b1;
                        state_next.ctl[c][`MDMA_CTL_ON] = 1'b0;
                        state_next.phase = mdma_pkg::PH_IDLE;
                    end else begin
                        // zero-extend at the source size, cut at destination
                        item = cmd_rdata & size_mask(state_reg.cmd_size);
                        state_next.cmd_valid  = 1'b1;
                        state_next.cmd_write  = 1'b1;
                        state_next.cmd_to_per = state_reg.ctl[c][`MDMA_CTL_DIR];
                        state_next.cmd_size   = state_reg.ctl[c][`MDMA_CTL_DIR]
                            ? state_reg.ctl[c][`MDMA_CTL_PSIZE +: 2]
                            : state_reg.ctl[c][`MDMA_CTL_MSIZE +: 2];
                        state_next.cmd_addr   = state_reg.dst_addr;
                        state_next.cmd_wdata  = item & size_mask(state_next.cmd_size);
                        state_next.phase      = mdma_pkg::PH_WRITE;
                    end
                end
            end
            mdma_pkg::PH_WRITE: begin
                if (cmd_ready) begin
                    state_next.cmd_valid = 1'b0;
                    state_next.ack[c]    = on_per;
                    state_next.phase     = mdma_pkg::PH_IDLE;
                    if (cmd_err) begin
                        set_fault[c] = 1'b1;
                        state_next.ctl[c][`MDMA_CTL_ON] = 1'b0;
                    end else begin
                        left_new = state_reg.items_left[c] - CNT_W'(1);
                        half_pt  = state_reg.reload[c] - (state_reg.reload[c] >> 1);
                        if ((state_reg.reload[c] >> 1) != '0 && left_new == half_pt) begin
                            set_half[c] = 1'b1;
                        end
                        if (left_new == '0) begin
                            set_full[c] = 1'b1;
                            if (state_reg.ctl[c][`MDMA_CTL_CIRC]) begin
                                left_new = state_reg.reload[c];
                            end
                        end
                        state_next.items_left[c] = left_new;
                    end
                end
            end
            default: begin
                state_next.cmd_valid = 1'b0;
                state_next.phase     = mdma_pkg::PH_IDLE;
            end
        endcase

        // an event in the clearing cycle survives: set wins over clear
        for (int i = 0; i < NCH; i++) begin
            state_next.flags[i] = state_reg.flags[i] & ~clr_flags[i];
            state_next.flags[i][`MDMA_FLAG_FULL]  = state_next.flags[i][`MDMA_FLAG_FULL]
                                                  | set_full[i];
            state_next.flags[i][`MDMA_FLAG_HALF]  = state_next.flags[i][`MDMA_FLAG_HALF]
                                                  | set_half[i];
            state_next.flags[i][`MDMA_FLAG_FAULT] = state_next.flags[i][`MDMA_FLAG_FAULT]
                                                  | set_fault[i];
            state_next.flags[i][`MDMA_FLAG_ANY]   = state_next.flags[i][`MDMA_FLAG_ANY]
                | set_full[i] | set_half[i] | set_fault[i];
        end
    end

    // all engine state in one register
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg       <= '0;
            state_reg.phase <= mdma_pkg::PH_IDLE;
            state_reg.ctl   <= {NCH{`MDMA_CTL_RST}};
        end else begin
            state_reg <= state_next;
        end
    end

    // base addresses live in a memory; the engine reads on port b
    mdma_addr_mem #(
        .DEPTH  (NCH),
        .LANES  (2),
        .LANE_W (32),
        .IDX_W  (CH_W)
    ) u_base_mem (
        .clk_sys_in    (clk_sys_in),
        .reset_in      (reset_in),
        .wr_lane_in    (base_wr_lane),
        .wr_idx_in     (base_wr_idx),
        .wr_data_in    (reg_wdata_in),
        .rd_a_idx_in   (base_rd_a_idx),
        .rd_a_data_out (base_rd_a_data),
        .rd_b_idx_in   (base_rd_b_idx),
        .rd_b_data_out (base_rd_b_data)
    );

    // read data stand one cycle after the strobe
    assign reg_rdata_out = !state_reg.rd_mem ? state_reg.rdata
                         : state_reg.rd_hi ? base_rd_a_data[63:32] : base_rd_a_data[31:0];

    // one interrupt per channel: flag and its enable
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_irq
            assign irq_out[g] = |(state_reg.flags[g][`MDMA_FLAG_FAULT:`MDMA_FLAG_FULL]
                                & state_reg.ctl[g][`MDMA_CTL_FAULT_IE:`MDMA_CTL_FULL_IE]);
        end
    endgenerate

    // both masters share the command registers; valid picks the port
    assign periph_ack_out = state_reg.ack;
    assign per_valid_out  = state_reg.cmd_valid & state_reg.cmd_to_per;
    assign per_write_out  = state_reg.cmd_write;
    assign per_size_out   = state_reg.cmd_size;
    assign per_addr_out   = state_reg.cmd_addr;
    assign per_wdata_out  = state_reg.cmd_wdata;
    assign mem_valid_out  = state_reg.cmd_valid & ~state_reg.cmd_to_per;
    assign mem_write_out  = state_reg.cmd_write;
    assign mem_size_out   = state_reg.cmd_size;
    assign mem_addr_out   = state_reg.cmd_addr;
    assign mem_wdata_out  = state_reg.cmd_wdata;

endmodule : mdma_engine

// ===== rtl/mdma_consts.svh
// register offsets, control field positions, reset values and size codes
// of the multichannel transfer engine; definitions only
`ifndef MDMA_CONSTS_SVH
`define MDMA_CONSTS_SVH

// register map, byte offsets on the 8-bit register port
`define MDMA_OFF_FLAGS   8'h00
`define MDMA_OFF_CLEAR   8'h04
`define MDMA_OFF_CTL     8'h08
`define MDMA_OFF_CNT     8'h0C
`define MDMA_OFF_PADDR   8'h10
`define MDMA_OFF_MADDR   8'h14
`define MDMA_CH_STRIDE   8'h14

// channel control register fields
`define MDMA_CTL_W       15
`define MDMA_CTL_ON      0
`define MDMA_CTL_FULL_IE 1
`define MDMA_CTL_HALF_IE 2
`define MDMA_CTL_FAULT_IE 3
`define MDMA_CTL_DIR     4
`define MDMA_CTL_CIRC    5
`define MDMA_CTL_PSTEP   6
`define MDMA_CTL_MSTEP   7
`define MDMA_CTL_PSIZE   8
`define MDMA_CTL_MSIZE   10
`define MDMA_CTL_RANK    12
`define MDMA_CTL_M2M     14

// per-channel event flags, four bits per channel in flag and clear words
`define MDMA_FLAG_W      4
`define MDMA_FLAG_ANY    0
`define MDMA_FLAG_FULL   1
`define MDMA_FLAG_HALF   2
`define MDMA_FLAG_FAULT  3

// item size codes
`define MDMA_SIZE_8      2'h0
`define MDMA_SIZE_16     2'h1
`define MDMA_SIZE_32     2'h2

// reset values
`define MDMA_CTL_RST     15'h0000
`define MDMA_WORD_RST    32'h0000_0000

`endif

// ===== rtl/mdma_pkg.sv
// types shared by the transfer engine
// assumes nothing beyond a SystemVerilog compiler
package mdma_pkg;

    // engine phases, one-hot
    typedef enum logic [3:0] {
        PH_IDLE  = 4'b0001,
        PH_FETCH = 4'b0010,
        PH_READ  = 4'b0100,
        PH_WRITE = 4'b1000
    } mdma_phase_e;

endpackage : mdma_pkg

// ===== rtl/mdma_addr_mem.sv
// small base-address memory: one lane-masked write port, two read ports
// assumes one clock; read data are registered, valid the cycle after the index
module mdma_addr_mem #(
    parameter int DEPTH  = 7,
    parameter int LANES  = 2,
    parameter int LANE_W = 32,
    parameter int IDX_W  = 3
) (
    input  wire logic                    clk_sys_in,
    input  wire logic                    reset_in,
    input  wire logic [LANES-1:0]        wr_lane_in,
    input  wire logic [IDX_W-1:0]        wr_idx_in,
    input  wire logic [LANE_W-1:0]       wr_data_in,
    input  wire logic [IDX_W-1:0]        rd_a_idx_in,
    output logic      [LANES*LANE_W-1:0] rd_a_data_out,
    input  wire logic [IDX_W-1:0]        rd_b_idx_in,
    output logic      [LANES*LANE_W-1:0] rd_b_data_out
);

    typedef struct packed {
        logic [DEPTH-1:0][LANES-1:0][LANE_W-1:0] mem;
        logic [LANES-1:0][LANE_W-1:0]            rd_a;
        logic [LANES-1:0][LANE_W-1:0]            rd_b;
    } mdma_mem_s;

    mdma_mem_s mem_reg;
    mdma_mem_s mem_next;

    // read before write: a same-cycle write shows on the next read only
    always_comb begin
        mem_next      = mem_reg;
        mem_next.rd_a = mem_reg.mem[rd_a_idx_in];
        mem_next.rd_b = mem_reg.mem[rd_b_idx_in];
        for (int l = 0; l < LANES; l++) begin
            if (wr_lane_in[l]) begin
                mem_next.mem[wr_idx_in][l] = wr_data_in;
            end
        end
    end

    // small enough to clear on reset, so reads never return junk
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            mem_reg <= '0;
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rd_a_data_out = mem_reg.rd_a;
    assign rd_b_data_out = mem_reg.rd_b;

endmodule : mdma_addr_mem

// ===== test/mdma_engine_monitor.sv
// checker on master and acknowledge ports of the engine
// assumes a bind onto mdma_engine, one clock
module mdma_engine_monitor #(parameter int NCH = 7) (
    input wire logic clk_sys_in, reset_in, per_valid_out, per_ready_in,
    input wire logic mem_valid_out, mem_ready_in, mem_write_out,
    input wire logic [31:0] per_addr_out, mem_wdata_out,
    input wire logic [NCH-1:0] periph_req_in, periph_ack_out);
    timeunit 1ns; timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    sequence s_wr; mem_valid_out && mem_ready_in && mem_write_out; endsequence
    property p_one; !(per_valid_out && mem_valid_out); endproperty
    a_one: assert property (p_one) else $error("two commands");
    property p_ph; per_valid_out && !per_ready_in |=> per_valid_out && $stable(per_addr_out);
    endproperty
    a_ph: assert property (p_ph) else $error("read moved");
    property p_mh; mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_wdata_out);
    endproperty
    a_mh: assert property (p_mh) else $error("write moved");
    property p_gap; s_wr |=> !per_valid_out && !mem_valid_out; endproperty
    a_gap: assert property (p_gap) else $error("no idle after item");
    property p_ack; |periph_ack_out |-> $past(per_ready_in) && $past(per_valid_out); endproperty
    a_ack: assert property (p_ack) else $error("ack without access");
    property p_pulse; |periph_ack_out |=> periph_ack_out == '0; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_hot; $onehot0(periph_ack_out); endproperty
    a_hot: assert property (p_hot) else $error("two grants");
    property p_req; (periph_ack_out & ~periph_req_in) == '0; endproperty
    a_req: assert property (p_req) else $error("ack without request");
endmodule : mdma_engine_monitor
bind mdma_engine mdma_engine_monitor #(.NCH(NCH)) u_mon (.clk_sys_in, .reset_in,
    .per_valid_out, .per_ready_in, .mem_valid_out, .mem_ready_in, .mem_write_out,
    .per_addr_out, .mem_wdata_out, .periph_req_in, .periph_ack_out);

// ===== test/mdma_far_side.sv
// far-side bus slave: byte memory, one wait state, optional stall and error
// assumes the master holds its command until it sees ready
module mdma_far_side (
    input  wire logic        clk_sys_in, reset_in, vld_in, wr_in, st_in, fl_in,
    input  wire logic [1:0]  sz_in,
    input  wire logic [31:0] ad_in, wd_in,
    output logic             rdy_out = 1'b0, err_out = 1'b0,
    output logic      [31:0] rd_out = 32'h0000_0000);
    timeunit 1ns; timeprecision 1ps;
    logic [7:0] mem [256];
    logic       take;
    assign take = vld_in && !rdy_out && !st_in;
    // idle data toggles so a stale word never passes for an answer
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            rdy_out <= 1'b0;
            err_out <= 1'b0;
        end else begin
            rdy_out <= take;
            err_out <= take && fl_in;
            rd_out <= take ? {mem[ad_in[7:0] + 3], mem[ad_in[7:0] + 2], mem[ad_in[7:0] + 1],
                mem[ad_in[7:0]]} & (32'hFFFF_FFFF >> (8 * (4 - (1 << sz_in)))) : ~rd_out;
            for (int i = 0; i < 4; i++)
                if (take && wr_in && i < (1 << sz_in)) mem[ad_in[7:0] + i] <= wd_in[8*i +: 8];
        end
    end
endmodule : mdma_far_side

// ===== test/mdma_engine_tb_top.sv
// bench for the transfer engine: register tasks and scenario tasks
// assumes two far-side slave models; requests held until acknowledged
module mdma_engine_tb_top;
    timeunit 1ns; timeprecision 1ps;
    logic clk_sys_in = 0, reset_in = 1, reg_write_in = 0, reg_read_in = 0, fail = 0;
    logic [7:0] reg_addr_in = '0;
    logic [31:0] reg_wdata_in = '0, reg_rdata_out, rdq;
    logic [6:0] periph_req_in = '0, periph_ack_out, irq_out, want = '0;
    logic per_valid_out, per_write_out, per_ready_in, per_err_in;
    logic mem_valid_out, mem_write_out, mem_ready_in, mem_err_in;
    logic [1:0] per_size_out, mem_size_out;
    logic [31:0] per_addr_out, per_wdata_out, per_rdata_in;
    logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
    int fail_count = 0, compares = 0;
    mdma_engine DUT (.*);
    mdma_far_side u_per (.clk_sys_in, .reset_in, .vld_in(per_valid_out), .wr_in(per_write_out),
        .st_in(1'b0), .fl_in(fail), .sz_in(per_size_out), .ad_in(per_addr_out),
        .wd_in(per_wdata_out), .rdy_out(per_ready_in), .err_out(per_err_in), .rd_out(per_rdata_in));
    mdma_far_side u_mem (.clk_sys_in, .reset_in, .vld_in(mem_valid_out), .wr_in(mem_write_out),
        .st_in(fail), .fl_in(1'b0), .sz_in(mem_size_out), .ad_in(mem_addr_out),
        .wd_in(mem_wdata_out), .rdy_out(mem_ready_in), .err_out(mem_err_in), .rd_out(mem_rdata_in));
    always #4 clk_sys_in = ~clk_sys_in;
    // request drops on the edge after its acknowledge
    always @(posedge clk_sys_in) periph_req_in <= want & ~periph_ack_out;
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clk_sys_in) reg_write_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wr
    task automatic rd(logic [7:0] a);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clk_sys_in) reg_read_in <= 1'b0;
        @(negedge clk_sys_in) rdq = reg_rdata_out;
        @(posedge clk_sys_in);
    endtask : rd
    task automatic wait_bit(int b);
        rdq = '0;
        for (int i = 0; i < 300 && rdq[b] !== 1'b1; i++) rd(8'h00);
    endtask : wait_bit
    // count and addresses first, control with enable last
    task automatic cfg(int c, logic [31:0] pa, logic [31:0] ma, logic [31:0] n, logic [31:0] ctl);
        wr(8'h10 + 8'(c * 20), pa);
        wr(8'h14 + 8'(c * 20), ma);
        wr(8'h0C + 8'(c * 20), n);
        wr(8'h08 + 8'(c * 20), ctl);
    endtask : cfg
    task automatic t_periph_mem;
        for (int i = 0; i < 16; i++) u_per.mem[i] = 8'(i + 16);
        cfg(0, 32'h0000_0000, 32'h0000_0040, 32'h0000_0004, 32'h0000_06C3);
        want <= 7'h01;
        wait_bit(1);
        for (int k = 0; k < 4; k++) chk("item", {8'(4*k + 17), 8'(4*k + 16)},
            {u_mem.mem[65 + 2*k], u_mem.mem[64 + 2*k]});
        rd(8'h0C); chk("count", 32'h0000_0000, rdq);
        rd(8'h00); chk("flags", 32'h0000_0007, rdq);
        chk("irq", 32'h0000_0001, irq_out[0]);
        wr(8'h04, 32'h0000_0001); rd(8'h00); chk("clear", 32'h0000_0000, rdq);
        rd(8'hFC); chk("unmapped", 32'h0000_0000, rdq);
    endtask : t_periph_mem
    task automatic t_rank;
        for (int c = 1; c < 4; c++) cfg(c, 0, 32'h0000_0080, 1, c == 1 ? 32'h1001 : 32'h3001);
        @(posedge clk_sys_in) want <= 7'h0E;
        for (int i = 0; i < 100 && periph_ack_out === 7'h00; i++) @(negedge clk_sys_in);
        chk("grant", 32'h0000_0004, periph_ack_out);
        wait_bit(5);
        chk("flags", 32'h0000_3330, rdq);
    endtask : t_rank
    task automatic t_m2m_fault;
        cfg(4, 32'h0000_0000, 32'h0000_00C0, 2, 32'h0000_4841);
        wait_bit(17);
        chk("wide", 32'h0000_0011, {u_mem.mem[195], u_mem.mem[194], u_mem.mem[193],
            u_mem.mem[192]});
        fail <= 1'b1;
        cfg(5, 32'h0000_0000, 32'h0000_00C8, 1, 32'h0000_4009);
        wait_bit(23);
        fail <= 1'b0;
        chk("fault", 32'h0000_0009, rdq[23:20]);
        chk("irq", 32'h0000_0001, irq_out[5]);
    endtask : t_m2m_fault
    task automatic summarize;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        t_periph_mem;
        t_rank;
        t_m2m_fault;
        summarize;
    end
    // watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
endmodule : mdma_engine_tb_top
